// [design/dtm_pkg.sv]
// package of constants and types for the terminal mode decoder
package dtm_pkg;

  // =========================================================
  // input vector layout (index of each opto input)
  localparam int unsigned NUM_IN      = 9;
  localparam int unsigned IN_ENABLE   = 0;
  localparam int unsigned IN_FWD      = 1;
  localparam int unsigned IN_REV      = 2;
  localparam int unsigned IN_SEL_A    = 3;
  localparam int unsigned IN_SEL_B    = 4;
  localparam int unsigned IN_SEL_C    = 5;
  localparam int unsigned IN_SEL_D    = 6;
  localparam int unsigned IN_SEL_E    = 7;
  localparam int unsigned IN_EXT_TRIP = 8;

  // =========================================================
  // timing: debounce time and clock rate
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned FILT_TIME_US   = 10;
  localparam int unsigned FILT_CYC       =
    (FILT_TIME_US * (CLK_HZ / 1_000_000) < 1) ? 1 :
    FILT_TIME_US * (CLK_HZ / 1_000_000);
  localparam int unsigned FILT_W         = 8;
  localparam logic [FILT_W-1:0] FILT_MAX = FILT_W'(FILT_CYC - 1);

  // =========================================================
  // terminal operating modes
  typedef enum logic [1:0] {
    DTM_MODE_PROCESS  = 2'h0,
    DTM_MODE_3SPD_2W  = 2'h1,
    DTM_MODE_3SPD_3W  = 2'h2,
    DTM_MODE_FANPUMP3 = 2'h3
  } dtm_mode_e;

  // speed reference source codes
  typedef enum logic [2:0] {
    DTM_SRC_CMD_PARAM = 3'h0,
    DTM_SRC_PRESET1   = 3'h1,
    DTM_SRC_PRESET2   = 3'h2,
    DTM_SRC_PRESET3   = 3'h3,
    DTM_SRC_KEYPAD    = 3'h4,
    DTM_SRC_ANALOG1   = 3'h5
  } dtm_src_e;

  // three-wire run latch states
  typedef enum logic [2:0] {
    DTM_RUN_IDLE = 3'h1,
    DTM_RUN_FWD  = 3'h2,
    DTM_RUN_REV  = 3'h4
  } dtm_run_e;

  // reset values
  localparam logic [NUM_IN-1:0] IN_RST = 9'h000;

endpackage

// [design/dtm_in_if.sv]
// interface carrying filtered opto inputs from the filter to the decoder
`timescale 1ns/1ps
interface dtm_in_if;
  logic [dtm_pkg::NUM_IN-1:0] level;
  logic [dtm_pkg::NUM_IN-1:0] rise;
  modport src (output level, output rise);
  modport dst (input  level, input  rise);
endinterface

// [design/dtm_filter.sv]
// two-flop synchroniser and debounce filter for the opto inputs
`timescale 1ns/1ps
module dtm_filter (
  input  wire logic                       core_clk_i,
  input  wire logic                       sys_rst_i,
  input  wire logic [dtm_pkg::NUM_IN-1:0] pin_i,
  dtm_in_if.src                           filt
);

  // =========================================================
  // synchroniser
  logic [dtm_pkg::NUM_IN-1:0] meta_q;
  logic [dtm_pkg::NUM_IN-1:0] sync_q;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_q <= dtm_pkg::IN_RST;
      sync_q <= dtm_pkg::IN_RST;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
    end
  end

  // =========================================================
  // debounce: level changes only after a stable run of samples
  logic [dtm_pkg::NUM_IN-1:0] lvl_q;
  logic [dtm_pkg::NUM_IN-1:0] rise_q;
  logic [dtm_pkg::FILT_W-1:0] cnt_q [dtm_pkg::NUM_IN];

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lvl_q  <= dtm_pkg::IN_RST;
      rise_q <= dtm_pkg::IN_RST;
      for (int i = 0; i < dtm_pkg::NUM_IN; i++) begin
        cnt_q[i] <= '0;
      end
    end else begin
      for (int i = 0; i < dtm_pkg::NUM_IN; i++) begin
        rise_q[i] <= 1'b0;
        if (sync_q[i] == lvl_q[i]) begin
          cnt_q[i] <= '0;
        end else if (cnt_q[i] == dtm_pkg::FILT_MAX) begin
          cnt_q[i]  <= '0;
          lvl_q[i]  <= sync_q[i];
          rise_q[i] <= sync_q[i];
        end else begin
          cnt_q[i] <= cnt_q[i] + 1'b1;
        end
      end
    end
  end

  assign filt.level = lvl_q;
  assign filt.rise  = rise_q;

endmodule

// [design/dtm_mode_decode.sv]
// pure decode of preset selections into a speed source code
`timescale 1ns/1ps
module dtm_mode_decode (
  input  wire logic              fire_closed_i,
  input  wire logic              freeze_closed_i,
  input  wire logic              spd_src_closed_i,
  input  wire logic              psel1_closed_i,
  input  wire logic              psel2_closed_i,
  output dtm_pkg::dtm_src_e      fanpump_src_o,
  output dtm_pkg::dtm_src_e      preset_src_o
);

  // fan-pump three-wire speed select
  always_comb begin
    if (!fire_closed_i) begin
      fanpump_src_o = dtm_pkg::DTM_SRC_PRESET1;
    end else if (!freeze_closed_i) begin
      fanpump_src_o = dtm_pkg::DTM_SRC_PRESET2;
    end else if (!spd_src_closed_i) begin
      fanpump_src_o = dtm_pkg::DTM_SRC_KEYPAD;
    end else begin
      fanpump_src_o = dtm_pkg::DTM_SRC_CMD_PARAM;
    end
  end

  // three-speed analog preset select
  always_comb begin
    case ({psel2_closed_i, psel1_closed_i})
      2'h1:    preset_src_o = dtm_pkg::DTM_SRC_PRESET1;
      2'h2:    preset_src_o = dtm_pkg::DTM_SRC_PRESET2;
      2'h3:    preset_src_o = dtm_pkg::DTM_SRC_PRESET3;
      default: preset_src_o = dtm_pkg::DTM_SRC_CMD_PARAM;
    endcase
  end

endmodule

// [design/dtm_top.sv]
// terminal input command decoder for the drive
// =========================================================
`timescale 1ns/1ps
module dtm_top (
  input  wire logic                       core_clk_i,
  input  wire logic                       sys_rst_i,
  input  wire logic [dtm_pkg::NUM_IN-1:0] opto_closed_i,
  input  wire logic [1:0]                 term_mode_i,
  input  wire logic                       open_vector_i,
  input  wire logic                       ext_trip_en_i,
  input  wire logic                       cmd_src_is_ai1_i,
  input  wire logic                       unipolar_cmd_i,
  input  wire logic                       fault_active_i,
  output logic                            drive_enable_o,
  output logic                            coast_o,
  output logic                            run_fwd_o,
  output logic                            run_rev_o,
  output logic                            decel_stop_o,
  output logic                            zero_current_stop_o,
  output logic                            table2_o,
  output logic                            ramp_group2_o,
  output logic                            torque_mode_o,
  output logic                            pid_enable_o,
  output logic                            pid_int_clear_o,
  output logic                            jog_enable_o,
  output logic                            fault_reset_o,
  output logic                            ext_trip_fault_o,
  output logic                            terminal_ctrl_o,
  output logic                            source_change_o,
  output logic [2:0]                      speed_src_o
);

  // =========================================================
  // input filtering
  dtm_in_if filt ();

  dtm_filter u_filter (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .pin_i      (opto_closed_i),
    .filt       (filt)
  );

  logic en_c;
  logic fwd_c;
  logic rev_c;
  logic sa_c;
  logic sb_c;
  logic sc_c;
  logic sd_c;
  logic se_c;
  logic trip_c;
  dtm_pkg::dtm_mode_e mode_c;

  assign en_c   = filt.level[dtm_pkg::IN_ENABLE];
  assign fwd_c  = filt.level[dtm_pkg::IN_FWD];
  assign rev_c  = filt.level[dtm_pkg::IN_REV];
  assign sa_c   = filt.level[dtm_pkg::IN_SEL_A];
  assign sb_c   = filt.level[dtm_pkg::IN_SEL_B];
  assign sc_c   = filt.level[dtm_pkg::IN_SEL_C];
  assign sd_c   = filt.level[dtm_pkg::IN_SEL_D];
  assign se_c   = filt.level[dtm_pkg::IN_SEL_E];
  assign trip_c = filt.level[dtm_pkg::IN_EXT_TRIP];
  assign mode_c = dtm_pkg::dtm_mode_e'(term_mode_i);

  logic is_proc_c;
  logic is_2w_c;
  logic is_3w_c;
  logic is_3spd_c;
  assign is_proc_c = (mode_c == dtm_pkg::DTM_MODE_PROCESS);
  assign is_2w_c   = (mode_c == dtm_pkg::DTM_MODE_3SPD_2W);
  assign is_3w_c   = (mode_c == dtm_pkg::DTM_MODE_3SPD_3W) ||
                     (mode_c == dtm_pkg::DTM_MODE_FANPUMP3);
  assign is_3spd_c = is_2w_c || (mode_c == dtm_pkg::DTM_MODE_3SPD_3W);

  // =========================================================
  // speed source decode
  dtm_pkg::dtm_src_e fp_src_c;
  dtm_pkg::dtm_src_e pre_src_c;

  dtm_mode_decode u_decode (
    .fire_closed_i    (sd_c),
    .freeze_closed_i  (se_c),
    .spd_src_closed_i (sc_c),
    .psel1_closed_i   (sd_c),
    .psel2_closed_i   (se_c),
    .fanpump_src_o    (fp_src_c),
    .preset_src_o     (pre_src_c)
  );

  function automatic dtm_pkg::dtm_src_e pick_src(
    input dtm_pkg::dtm_mode_e m,
    input logic               ana_sel,
    input logic               spd_sel,
    input logic               ai1_param,
    input dtm_pkg::dtm_src_e  fp,
    input dtm_pkg::dtm_src_e  pre
  );
    dtm_pkg::dtm_src_e s;
    s = dtm_pkg::DTM_SRC_CMD_PARAM;
    if (m == dtm_pkg::DTM_MODE_FANPUMP3) begin
      s = fp;
    end else if (m == dtm_pkg::DTM_MODE_PROCESS) begin
      s = dtm_pkg::DTM_SRC_CMD_PARAM;
    end else if (!spd_sel) begin
      s = dtm_pkg::DTM_SRC_KEYPAD;
    end else if (pre != dtm_pkg::DTM_SRC_CMD_PARAM) begin
      s = pre;
    end else if (m == dtm_pkg::DTM_MODE_3SPD_2W &&
                 (ana_sel || ai1_param)) begin
      s = dtm_pkg::DTM_SRC_ANALOG1;
    end else begin
      s = dtm_pkg::DTM_SRC_CMD_PARAM;
    end
    return s;
  endfunction

  // =========================================================
  // fault reset and external trip
  logic both_c;
  logic trip_fault_c;
  assign both_c       = fwd_c && rev_c;
  assign trip_fault_c = ext_trip_en_i && !trip_c;

  logic fault_c;
  assign fault_c = fault_active_i || trip_fault_c;

  logic rst_cmd_c;
  always_comb begin
    rst_cmd_c = 1'b0;
    if (is_proc_c) begin
      rst_cmd_c = se_c;
    end else if (is_3spd_c || mode_c == dtm_pkg::DTM_MODE_FANPUMP3) begin
      rst_cmd_c = both_c && (sb_c || mode_c ==
                             dtm_pkg::DTM_MODE_FANPUMP3);
    end
  end

  // =========================================================
  // three-wire run latch
  dtm_pkg::dtm_run_e run_q;
  logic              stop_open_c;
  assign stop_open_c = !sa_c;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      run_q <= dtm_pkg::DTM_RUN_IDLE;
    end else if (!is_3w_c || !en_c || fault_c) begin
      run_q <= dtm_pkg::DTM_RUN_IDLE;
    end else if (stop_open_c) begin
      run_q <= dtm_pkg::DTM_RUN_IDLE;
    end else begin
      case (run_q)
        dtm_pkg::DTM_RUN_IDLE: begin
          if (filt.rise[dtm_pkg::IN_FWD] && !rev_c) begin
            run_q <= dtm_pkg::DTM_RUN_FWD;
          end else if (filt.rise[dtm_pkg::IN_REV] && !fwd_c) begin
            run_q <= dtm_pkg::DTM_RUN_REV;
          end
        end
        dtm_pkg::DTM_RUN_FWD: begin
          if (filt.rise[dtm_pkg::IN_REV] && !fwd_c) begin
            run_q <= dtm_pkg::DTM_RUN_REV;
          end
        end
        dtm_pkg::DTM_RUN_REV: begin
          if (filt.rise[dtm_pkg::IN_FWD] && !rev_c) begin
            run_q <= dtm_pkg::DTM_RUN_FWD;
          end
        end
        default: run_q <= dtm_pkg::DTM_RUN_IDLE;
      endcase
    end
  end

  // =========================================================
  // run request decode
  logic want_fwd_c;
  logic want_rev_c;
  always_comb begin
    want_fwd_c = 1'b0;
    want_rev_c = 1'b0;
    if (is_proc_c) begin
      want_fwd_c = fwd_c;
      want_rev_c = rev_c && !fwd_c;
    end else if (is_2w_c) begin
      want_fwd_c = fwd_c && !rev_c;
      want_rev_c = rev_c && !fwd_c;
    end else if (is_3w_c) begin
      want_fwd_c = (run_q == dtm_pkg::DTM_RUN_FWD);
      want_rev_c = (run_q == dtm_pkg::DTM_RUN_REV);
    end
  end

  // =========================================================
  // registered command outputs
  logic term_q;
  logic kp_run_fwd_q;
  logic kp_run_rev_q;
  logic [2:0] src_q;
  logic run_f_q;
  logic run_r_q;
  logic prime_q;

  // keypad source: hold last direction across switchover
  logic term_ctrl_c;
  assign term_ctrl_c = is_proc_c || sb_c;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      kp_run_fwd_q <= 1'b0;
      kp_run_rev_q <= 1'b0;
    end else if (!en_c || fault_c) begin
      kp_run_fwd_q <= 1'b0;
      kp_run_rev_q <= 1'b0;
    end else if (term_ctrl_c) begin
      kp_run_fwd_q <= want_fwd_c;
      kp_run_rev_q <= want_rev_c;
    end
  end

  logic run_f_d;
  logic run_r_d;
  always_comb begin
    run_f_d = term_ctrl_c ? want_fwd_c : kp_run_fwd_q;
    run_r_d = term_ctrl_c ? want_rev_c : kp_run_rev_q;
    if (!en_c || trip_fault_c) begin
      run_f_d = 1'b0;
      run_r_d = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      run_f_q <= 1'b0;
      run_r_q <= 1'b0;
      term_q  <= 1'b0;
      prime_q <= 1'b0;
      src_q   <= dtm_pkg::DTM_SRC_CMD_PARAM;
    end else begin
      run_f_q <= run_f_d;
      run_r_q <= run_r_d;
      term_q  <= term_ctrl_c;
      prime_q <= 1'b1;
      src_q   <= pick_src(mode_c, sa_c, sc_c, cmd_src_is_ai1_i,
                          fp_src_c, pre_src_c);
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      drive_enable_o      <= 1'b0;
      coast_o             <= 1'b1;
      decel_stop_o        <= 1'b0;
      zero_current_stop_o <= 1'b0;
      table2_o            <= 1'b0;
      ramp_group2_o       <= 1'b0;
      torque_mode_o       <= 1'b0;
      pid_enable_o        <= 1'b0;
      pid_int_clear_o     <= 1'b1;
      jog_enable_o        <= 1'b0;
      fault_reset_o       <= 1'b0;
      ext_trip_fault_o    <= 1'b0;
    end else begin
      drive_enable_o   <= en_c;
      coast_o          <= !en_c;
      decel_stop_o     <= en_c && !run_f_d && !run_r_d;
      zero_current_stop_o <= en_c && !run_f_d && !run_r_d &&
                             is_proc_c && open_vector_i && sb_c;
      table2_o         <= is_proc_c && sa_c;
      ramp_group2_o    <= is_proc_c && !open_vector_i && sb_c;
      torque_mode_o    <= is_proc_c && open_vector_i && sb_c;
      pid_enable_o     <= is_proc_c && sc_c;
      pid_int_clear_o  <= !(is_proc_c && sc_c);
      jog_enable_o     <= is_proc_c && sd_c && (fwd_c || rev_c);
      fault_reset_o    <= rst_cmd_c;
      ext_trip_fault_o <= trip_fault_c;
    end
  end

  assign run_fwd_o       = run_f_q;
  assign run_rev_o       = run_r_q;
  assign terminal_ctrl_o = term_q;
  assign speed_src_o     = src_q;
  // no change flag until term_q has taken its first real value
  assign source_change_o = prime_q && (term_q != term_ctrl_c);

  // =========================================================
  // assertions
  AST_COAST_ON_DISABLE: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) !en_c |=> coast_o && !run_fwd_o && !run_rev_o)
    else $error("run while enable open");
  AST_NO_BOTH_RUN: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) !(run_fwd_o && run_rev_o))
    else $error("both directions active");
  AST_TRIP: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) trip_fault_c |=> ext_trip_fault_o)
    else $error("trip not raised");
  AST_NO_TRIP_OFF: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) !ext_trip_en_i |=> !ext_trip_fault_o)
    else $error("trip raised while disabled");
  AST_LATCH_HOLD: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i)
    run_q == dtm_pkg::DTM_RUN_FWD && en_c && sa_c && !fault_c &&
    is_3w_c && !filt.rise[dtm_pkg::IN_REV]
    |=> run_q == dtm_pkg::DTM_RUN_FWD)
    else $error("three-wire run dropped");
  AST_STOP_CLEARS: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) is_3w_c && !sa_c
    |=> run_q == dtm_pkg::DTM_RUN_IDLE)
    else $error("stop did not cancel run");
  AST_FAULT_CLEARS: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) fault_c |=> run_q == dtm_pkg::DTM_RUN_IDLE)
    else $error("fault did not clear latch");
  AST_PID: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) pid_enable_o |-> !pid_int_clear_o)
    else $error("pid and clear together");
  AST_RESET_2W: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) is_2w_c && both_c && sb_c |=> fault_reset_o)
    else $error("both closed gave no reset");
  AST_UNI_BOTH_STOP: assert property (@(posedge core_clk_i)
    disable iff (sys_rst_i) is_2w_c && unipolar_cmd_i && both_c && sb_c
    |=> !run_fwd_o && !run_rev_o)
    else $error("unipolar ran with both closed");

  COV_3W_RUN: cover property (@(posedge core_clk_i)
    run_q == dtm_pkg::DTM_RUN_FWD);
  COV_PROC_JOG: cover property (@(posedge core_clk_i) jog_enable_o);
  COV_SWITCH: cover property (@(posedge core_clk_i)
    source_change_o && run_fwd_o);

endmodule

// [verif/dtm_contact_model.sv]
// contact model for the switches wired to the opto inputs
`timescale 1ns/1ps
module dtm_contact_model (
  input  wire logic                       core_clk_i,
  output logic [dtm_pkg::NUM_IN-1:0]      closed_o
);
  initial closed_o = '0;

  // =========================================================
  // steady contact levels, changed just after a rising edge
  task automatic hold(input logic [dtm_pkg::NUM_IN-1:0] v);
    @(posedge core_clk_i);
    #1;
    closed_o = v;
  endtask

  // =========================================================
  // momentary close of a start contact or open of the stop contact
  task automatic pulse(input int unsigned b, input int unsigned cyc);
    @(posedge core_clk_i);
    #1;
    closed_o[b] = ~closed_o[b];
    repeat (cyc) @(posedge core_clk_i);
    #1;
    closed_o[b] = ~closed_o[b];
  endtask
endmodule

// [verif/drive_terminal_mode_decoder_bench.sv]
// self-checking bench for the terminal mode decoder
`timescale 1ns/1ps
`define CMP(n, e, g) begin compares++; if ((g) !== (e)) begin \
  failures++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module drive_terminal_mode_decoder_bench;
  typedef struct {
    string       nm;
    logic [18:0] mask;
    logic [18:0] val;
  } dtm_note_s;

  logic                        core_clk_i;
  logic                        sys_rst_i;
  logic [1:0]                  mode;
  logic                        ov, te, ai1, flt;
  logic [dtm_pkg::NUM_IN-1:0]  pins;
  logic                        den, cst, rf, rr, dst, zcs, tb2, rg2, tq;
  logic                        pid, pclr, jog, frs, trp, term, schg;
  logic                        chg, uni;
  logic [2:0]                  spd;
  logic [18:0]                 obs;
  dtm_note_s                   exp_q[$];
  dtm_note_s                   item;
  event                        chk_ev;
  int                          failures, compares, cyc, w;

  assign obs = {spd, chg, term, trp, frs, jog, pclr, pid, tq, rg2, tb2,
                zcs, dst, rr, rf, cst, den};

  dtm_contact_model u_dtm_contact_model (
    .core_clk_i (core_clk_i),
    .closed_o   (pins)
  );

  dtm_top u_dtm_top (
    .core_clk_i          (core_clk_i),
    .sys_rst_i           (sys_rst_i),
    .opto_closed_i       (pins),
    .term_mode_i         (mode),
    .open_vector_i       (ov),
    .ext_trip_en_i       (te),
    .cmd_src_is_ai1_i    (ai1),
    .unipolar_cmd_i      (uni),
    .fault_active_i      (flt),
    .drive_enable_o      (den),
    .coast_o             (cst),
    .run_fwd_o           (rf),
    .run_rev_o           (rr),
    .decel_stop_o        (dst),
    .zero_current_stop_o (zcs),
    .table2_o            (tb2),
    .ramp_group2_o       (rg2),
    .torque_mode_o       (tq),
    .pid_enable_o        (pid),
    .pid_int_clear_o     (pclr),
    .jog_enable_o        (jog),
    .fault_reset_o       (frs),
    .ext_trip_fault_o    (trp),
    .terminal_ctrl_o     (term),
    .source_change_o     (schg),
    .speed_src_o         (spd)
  );

  // =========================================================
  // clock, hang guard, verdict
  initial core_clk_i = 1'b0;
  always #50 core_clk_i = ~core_clk_i;

  // sticky record of the one-cycle source change pulse
  always @(posedge core_clk_i) begin
    if (schg === 1'b1) begin
      chg <= 1'b1;
    end
  end

  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish;
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // =========================================================
  // monitor takes every queued note, oldest first, whenever results are ready
  always begin
    @(chk_ev);
    while (exp_q.size() > 0) begin
      item = exp_q.pop_front();
      `CMP(item.nm, item.val, obs & item.mask)
    end
  end

  task automatic cfg(input logic [1:0] m, input logic o, t, a, f);
    @(posedge core_clk_i);
    #1;
    mode = m;
    ov = o;
    te = t;
    ai1 = a;
    flt = f;
  endtask

  task automatic note(input string n, input logic [18:0] m, v);
    repeat (110) @(posedge core_clk_i);
    #1;
    exp_q.push_back('{n, m, v});
    ->chk_ev;
  endtask

  task automatic step(input logic [8:0] p, input string n,
                      input logic [18:0] m, v);
    u_dtm_contact_model.hold(p);
    note(n, m, v);
  endtask

  // =========================================================
  // main sequence; pins: 1 en, 2 fwd, 4 rev, 8 a, 10 b, 20 c, 40 d,
  // 80 e, 100 trip
  initial begin
    failures = 0;
    compares = 0;
    cyc = 0;
    chg = 1'b0;
    uni = 1'b1;
    sys_rst_i = 1'b1;
    {mode, ov, te, ai1, flt} = '0;
    void'($urandom(32'hc6222344));
    repeat (10) @(posedge core_clk_i);
    #1;
    sys_rst_i = 1'b0;
    cfg(2'h0, 1'b0, 1'b1, 1'b0, 1'b0);
    step(9'h100, "coast", 19'h00003, 19'h00002);
    step(9'h103, "fwd", 19'h0001f, 19'h00005);
    step(9'h105, "rev", 19'h0001c, 19'h00008);
    step(9'h101, "stop", 19'h0001c, 19'h00010);
    step(9'h109, "table", 19'h00040, 19'h00040);
    step(9'h111, "ramp", 19'h00180, 19'h00080);
    cfg(2'h0, 1'b1, 1'b1, 1'b0, 1'b0);
    step(9'h111, "torque", 19'h001a0, 19'h00120);
    step(9'h121, "pid on", 19'h00600, 19'h00200);
    step(9'h101, "pid off", 19'h00600, 19'h00400);
    step(9'h143, "jog", 19'h00800, 19'h00800);
    step(9'h181, "freset", 19'h01000, 19'h01000);
    step(9'h001, "trip", 19'h02000, 19'h02000);
    cfg(2'h0, 1'b1, 1'b0, 1'b0, 1'b0);
    note("no trip", 19'h02000, 19'h00000);
    step(9'h101, "idle", 19'h0000c, 19'h00000);
    w = $urandom_range(90, 5);
    u_dtm_contact_model.pulse(dtm_pkg::IN_FWD, w);
    note("glitch", 19'h0000c, 19'h00000);
    cfg(2'h3, 1'b0, 1'b1, 1'b0, 1'b0);
    step(9'h101, "fp p1", 19'h70000, 19'h10000);
    step(9'h141, "fp p2", 19'h70000, 19'h20000);
    step(9'h1c1, "fp kpd", 19'h70000, 19'h40000);
    step(9'h1e1, "fp cmd", 19'h70000, 19'h00000);
    cfg(2'h1, 1'b0, 1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 4; i++) begin
      step(9'h131 | 9'(i << 6), "preset", 19'h70000, 19'(i << 16));
    end
    step(9'h139, "ana", 19'h70000, 19'h50000);
    cfg(2'h1, 1'b0, 1'b1, 1'b1, 1'b0);
    step(9'h131, "ana frc", 19'h70000, 19'h50000);
    step(9'h111, "kpd spd", 19'h70000, 19'h40000);
    chg = 1'b0;
    step(9'h133, "2w fwd", 19'h0401c, 19'h04004);
    step(9'h137, "2w both", 19'h0100c, 19'h01000);
    step(9'h133, "2w fwd", 19'h0800c, 19'h00004);
    step(9'h123, "swap", 19'h0c00c, 19'h08004);
    step(9'h135, "2w rev", 19'h0000c, 19'h00008);
    step(9'h131, "2w off", 19'h0001c, 19'h00010);
    cfg(2'h2, 1'b0, 1'b1, 1'b0, 1'b0);
    step(9'h119, "3w idle", 19'h0001c, 19'h00010);
    u_dtm_contact_model.pulse(dtm_pkg::IN_FWD, 120);
    note("3w fwd", 19'h0001c, 19'h00004);
    u_dtm_contact_model.pulse(dtm_pkg::IN_SEL_A, 120);
    note("3w stop", 19'h0001c, 19'h00010);
    u_dtm_contact_model.pulse(dtm_pkg::IN_REV, 120);
    note("3w rev", 19'h0001c, 19'h00008);
    cfg(2'h2, 1'b0, 1'b1, 1'b0, 1'b1);
    cfg(2'h2, 1'b0, 1'b1, 1'b0, 1'b0);
    note("3w flt", 19'h0000c, 19'h00000);
    u_dtm_contact_model.pulse(dtm_pkg::IN_FWD, 120);
    u_dtm_contact_model.pulse(dtm_pkg::IN_ENABLE, 120);
    note("3w dis", 19'h0000c, 19'h00000);
    @(posedge core_clk_i);
    #1;
    sys_rst_i = 1'b1;
    note("reset", 19'h77fff, 19'h00402);
    @(posedge core_clk_i);
    tally_and_finish();
  end
endmodule
